// file: dv/aom_axis_mode_ctrl_props.sv
// checker: status-word and run-control properties of the axis mode core
module aom_axis_mode_ctrl_props
  import aom_pkg::*;
#(
  parameter int DIV = PULSE_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host access
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd,
  input wire logic [31:0] o_rdata,
  input wire logic [3:0] i_lin1_set,
  input wire logic [3:0] i_lin2_set,
  input wire logic [3:0] i_circ_set,
  input wire logic [3:0] i_const_speed,
  // operation
  input wire logic [6:0] i_mode_select,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic signed [31:0] i_move_amount,
  input wire logic [31:0] i_decel_point,
  input wire logic i_high_speed,
  input wire logic o_pulse,
  input wire logic o_dir_minus,
  input wire logic o_busy,
  input wire logic o_decel,
  input wire logic o_done,
  input wire logic [31:0] o_remaining_pulses,
  input wire logic [6:0] o_mode_register
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_ev;
  logic idle_start;
  assign rd_ev = (i_rd && (i_addr == INTERP_STATUS_ADDR_A || i_addr == INTERP_STATUS_ADDR_B))
    || (i_cmd_wr && i_cmd == READ_INTERP_STATUS_CMD);
  // the core is idle from its done cycle until the next start is taken
  logic run_pending_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_pending_q <= 1'b0;
    end else if (idle_start) begin
      run_pending_q <= 1'b1;
    end else if (o_done) begin
      run_pending_q <= 1'b0;
    end
  end
  assign idle_start = i_start && (!run_pending_q || o_done);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  a_status_cfg_bits:
    assert property (rd_ev |=> o_rdata[15:0] ==
      {$past(i_const_speed), $past(i_circ_set), $past(i_lin2_set), $past(i_lin1_set)})
    else $error("status config bits differ from axis flags");
  a_status_top_zero:
    assert property (rd_ev |=> o_rdata[31:24] == 8'h00)
    else $error("status top byte not zero");
  a_zero_start_done:
    assert property (idle_start && i_mode_select == MODE_INCR && i_move_amount == 0
      |-> !o_pulse throughout (##[1:2] o_done))
    else $error("zero move did not complete cleanly");
  a_stop_ends_run:
    assert property (o_busy && i_stop |=> !o_busy ##[0:1] o_done)
    else $error("stop did not end the run");
  a_pulse_counts_down:
    assert property (o_pulse && o_mode_register == MODE_INCR
      |-> o_remaining_pulses == $past(o_remaining_pulses) - 32'h1)
    else $error("remaining count not decremented by pulse");
  a_dir_held_run:
    assert property (o_busy && $past(o_busy) |-> $stable(o_dir_minus))
    else $error("direction changed during a run");
  a_decel_flag:
    assert property (o_busy && o_mode_register == MODE_INCR
      |-> o_decel == (i_high_speed && o_remaining_pulses < i_decel_point))
    else $error("deceleration flag wrong");
  a_mode_latch:
    assert property (idle_start |=> o_mode_register == $past(i_mode_select))
    else $error("mode not latched at start");
  a_done_single:
    assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  cover property (idle_start && i_move_amount == 0);
  cover property (o_busy && i_stop);
  cover property (o_pulse && o_dir_minus);
endmodule : aom_axis_mode_ctrl_props

bind aom_axis_mode_ctrl aom_axis_mode_ctrl_props #(.DIV(DIV)) aom_props_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .i_cmd_wr(i_cmd_wr),
  .i_cmd(i_cmd), .o_rdata(o_rdata), .i_lin1_set(i_lin1_set), .i_lin2_set(i_lin2_set),
  .i_circ_set(i_circ_set), .i_const_speed(i_const_speed), .i_mode_select(i_mode_select),
  .i_start(i_start), .i_stop(i_stop), .i_move_amount(i_move_amount),
  .i_decel_point(i_decel_point), .i_high_speed(i_high_speed), .o_pulse(o_pulse),
  .o_dir_minus(o_dir_minus), .o_busy(o_busy), .o_decel(o_decel), .o_done(o_done),
  .o_remaining_pulses(o_remaining_pulses), .o_mode_register(o_mode_register)
);

// file: dv/aom_axis_mode_ctrl_tb.sv
// testbench: directed scenarios for the axis mode core
module aom_axis_mode_ctrl_tb
  import aom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_rd, i_cmd_wr, i_start, i_stop, i_move_amount_wr, i_high_speed;
  logic [7:0] i_addr, i_cmd;
  logic [6:0] i_mode_select, o_mode_register;
  logic signed [31:0] i_move_amount, i_counter1, i_counter2, pos;
  logic [31:0] i_decel_point, o_rdata, o_remaining_pulses;
  logic [3:0] i_lin1_set, i_lin2_set, i_circ_set, i_const_speed;
  logic [1:0] i_current_quadrant, i_final_quadrant;
  logic o_pulse, o_dir_minus, o_busy, o_decel, o_done;
  int n_mismatch = 0;
  int checks = 0;
  // short pulse period keeps every run brief
  aom_axis_mode_ctrl #(.DIV(4)) aom_axis_mode_ctrl_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .i_cmd_wr(i_cmd_wr),
    .i_cmd(i_cmd), .o_rdata(o_rdata), .i_mode_select(i_mode_select), .i_start(i_start),
    .i_stop(i_stop), .i_move_amount_wr(i_move_amount_wr), .i_move_amount(i_move_amount),
    .i_decel_point(i_decel_point), .i_high_speed(i_high_speed), .i_counter1(i_counter1),
    .i_counter2(i_counter2), .i_lin1_set(i_lin1_set), .i_lin2_set(i_lin2_set),
    .i_circ_set(i_circ_set), .i_const_speed(i_const_speed),
    .i_current_quadrant(i_current_quadrant), .i_final_quadrant(i_final_quadrant),
    .o_pulse(o_pulse), .o_dir_minus(o_dir_minus), .o_busy(o_busy), .o_decel(o_decel),
    .o_done(o_done), .o_remaining_pulses(o_remaining_pulses),
    .o_mode_register(o_mode_register)
  );
  aom_drv_model aom_drv_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_pulse(o_pulse),
    .i_dir_minus(o_dir_minus), .o_pos(pos));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // -------------
  // helpers
  // -------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // one operation; sa is the wait count at which stop is raised, -1 for never
  task automatic op(input logic [6:0] m, input logic signed [31:0] a, input int sa,
    output logic signed [31:0] d);
    int n;
    logic signed [31:0] p;
    @(negedge i_clk);
    p = pos;
    i_mode_select = m;
    i_move_amount = a;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 3000) begin
      i_stop = (n == sa);
      @(negedge i_clk);
      n++;
    end
    i_stop = 1'b0;
    d = pos - p;
    chk("done", {31'h0, o_done}, 32'h1);
  endtask : op
  // -------------
  // scenarios
  // -------------
  task automatic t_status();
    logic [31:0] e;
    for (int k = 0; k < 4; k++) begin
      i_lin1_set = 4'h1 << k;
      i_lin2_set = 4'h8 >> k;
      i_circ_set = ~(4'h1 << k);
      i_const_speed = 4'h3 << k;
      i_current_quadrant = k[1:0];
      i_final_quadrant = ~k[1:0];
      i_addr = (k == 0) ? INTERP_STATUS_ADDR_A : (k == 1) ? INTERP_STATUS_ADDR_B : 8'h30;
      i_cmd = READ_INTERP_STATUS_CMD;
      i_rd = (k != 3);
      i_cmd_wr = (k == 3);
      // no circle runs here, so the quadrant fields and run bits read zero
      if (k != 2) e = {8'h00, 8'h00, 4'h3 << k, ~(4'h1 << k), 4'h8 >> k, 4'h1 << k};
      @(negedge i_clk);
      i_rd = 1'b0;
      i_cmd_wr = 1'b0;
      @(negedge i_clk);
      chk("status", o_rdata, e);
    end
    $display("t_status done");
  endtask : t_status
  task automatic t_table();
    logic [6:0] tm[10] = '{7'h41, 7'h41, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h4e, 7'h47};
    int ta[10] = '{3, -2, 0, 5, 0, 7, 7, 7, 7, 3};
    int te[10] = '{3, -2, 0, 3, 1, -2, 1, 1, -1, 0};
    logic signed [31:0] d;
    for (int i = 0; i < 10; i++) begin
      op(tm[i], ta[i], -1, d);
      chk("delta", d, te[i]);
      chk("rem", o_remaining_pulses, 32'h0);
    end
    $display("t_table done");
  endtask : t_table
  task automatic t_cont();
    logic signed [31:0] d;
    op(MODE_CONT_PLUS, 0, 12, d);
    chk("cont_plus", {31'h0, d > 0}, 32'h1);
    op(MODE_CONT_MINUS, 0, 12, d);
    chk("cont_minus", {31'h0, d < 0}, 32'h1);
    op(MODE_INCR, 100, 10, d);
    chk("pos_stop", {31'h0, d > 0 && d < 100}, 32'h1);
    $display("t_cont done");
  endtask : t_cont
  // the new amount lands right after a pulse so it never races a decrement
  task automatic t_reload();
    int n;
    logic signed [31:0] p;
    @(negedge i_clk);
    i_mode_select = MODE_INCR;
    i_move_amount = 50;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    n = 0;
    while (o_pulse !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    i_move_amount = 2;
    i_move_amount_wr = 1'b1;
    @(negedge i_clk);
    i_move_amount_wr = 1'b0;
    p = pos;
    chk("busy", {31'h0, o_busy}, 32'h1);
    chk("decel_off", {31'h0, o_decel}, 32'h0);
    while (o_pulse !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk("decel_on", {31'h0, o_decel}, 32'h1);
    while (o_done !== 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk("reload", pos - p, 32'h2);
    $display("t_reload done");
  endtask : t_reload
  task automatic t_unsup();
    logic [6:0] q[$] = '{7'h01, 7'h02, 7'h10, 7'h12, 7'h15, 7'h18, 7'h1a, 7'h1d, 7'h20,
      7'h22, 7'h24, 7'h28, 7'h2a, 7'h2c};
    logic signed [31:0] d;
    for (int c = 32'h51; c <= 32'h6d; c++) if (c < 32'h57 || c >= 32'h60) q.push_back(c[6:0]);
    foreach (q[i]) begin
      op(q[i], 5, -1, d);
      chk("unsup", d, 32'h0);
    end
    $display("t_unsup done");
  endtask : t_unsup
  initial begin
    {i_rd, i_cmd_wr, i_start, i_stop, i_move_amount_wr, i_addr, i_cmd, i_mode_select} = '0;
    {i_lin1_set, i_lin2_set, i_circ_set, i_const_speed} = '0;
    {i_current_quadrant, i_final_quadrant} = '0;
    i_rst = 1'b1;
    i_move_amount = 0;
    i_high_speed = 1'b1;
    i_decel_point = 32'h2;
    i_counter1 = 2;
    i_counter2 = -1;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    t_status();
    t_table();
    t_cont();
    t_reload();
    t_unsup();
    print_verdict();
  end
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
endmodule : aom_axis_mode_ctrl_tb

// file: dv/aom_drv_model.sv
// partner: motor driver model that integrates direction-qualified command pulses
module aom_drv_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // command side
  input wire logic i_pulse,
  input wire logic i_dir_minus,
  output logic signed [31:0] o_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pos <= 32'sh0;
    end else if (i_pulse) begin
      o_pos <= i_dir_minus ? o_pos - 32'sh1 : o_pos + 32'sh1;
    end
  end
endmodule : aom_drv_model

// file: logic/aom_axis_mode_ctrl.sv
// axis operation-mode decoder and executor with interpolation status word
// Notes on behaviour
// - status bits 0-3 flag linear-1 mode configured on axes one to four
// - status bits 4-7 flag linear-2 mode configured on axes one to four
// - status bits 8-11 flag circular mode configured on axes one to four
// - status bits 12-15 flag constant synthesized speed on axes one to four
// - bit 16 high while linear-1 runs, bit 17 while linear-2 runs
// - bit 18 high during clockwise circle, bit 19 during counter-clockwise circle
// - bits 21:20 give the current circular quadrant, 00 first to 11 fourth
// - bits 23:22 give the end-point quadrant with the same coding
// - status word read at 00h, FCh, or by indirect command FFh
// - code 00h runs continuous plus, 08h continuous minus, stop-command controlled
// - continuous modes pulse from start until stop, then complete
// - origin-return codes 10h 18h 12h 1Ah 15h 1Dh are recognised
// - sensor codes 20h 28h 22h 2Ah 24h 2Ch are recognised
// - positioning codes 41h to 47h and 4Eh are decoded
// - pulser codes 01h, 51h-55h and switch codes 02h, 56h are recognised
// - interpolation codes 60h-67h and pulser interpolation 68h-6Dh are recognised
// - writing move amount in positioning loads remaining count with its magnitude
// - a stop command ends positioning early
// - incremental start loads magnitude, plus when positive, minus when negative
// - high-speed profiles decelerate when remaining below decel point, stop at zero
// - completion when pulses stop; zero amount completes with no pulse
// - absolute modes move by magnitude of target minus counter, direction by sign
module aom_axis_mode_ctrl
  import aom_pkg::*;
#(
  parameter int DIV = PULSE_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host register access
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd,
  output logic [31:0] o_rdata,
  // operation control
  input wire logic [6:0] i_mode_select,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_move_amount_wr,
  input wire logic signed [31:0] i_move_amount,
  input wire logic [31:0] i_decel_point,
  input wire logic i_high_speed,
  input wire logic signed [31:0] i_counter1,
  input wire logic signed [31:0] i_counter2,
  // interpolation context from the axis group
  input wire logic [3:0] i_lin1_set,
  input wire logic [3:0] i_lin2_set,
  input wire logic [3:0] i_circ_set,
  input wire logic [3:0] i_const_speed,
  input wire logic [1:0] i_current_quadrant,
  input wire logic [1:0] i_final_quadrant,
  // motor driver side
  output logic o_pulse,
  output logic o_dir_minus,
  output logic o_busy,
  output logic o_decel,
  output logic o_done,
  output logic [31:0] o_remaining_pulses,
  output logic [6:0] o_mode_register
);
  // a period below two clocks would leave no low phase between pulses
  if (DIV < 2) begin : g_bad_div
    $error("DIV must be at least 2");
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // codes outside the defined set decode as bad and finish like unsupported ones
  function automatic aom_kind_e kind_of(input logic [6:0] m);
    aom_kind_e k;
    k = AOM_KIND_BAD;
    case (m)
      7'h00, 7'h08: k = AOM_KIND_CONT;
      7'h10, 7'h18, 7'h12, 7'h1a, 7'h15, 7'h1d: k = AOM_KIND_OTHER;
      7'h20, 7'h28, 7'h22, 7'h2a, 7'h24, 7'h2c: k = AOM_KIND_OTHER;
      7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h4e: k = AOM_KIND_POS;
      7'h47: k = AOM_KIND_TIMER;
      7'h01, 7'h02, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56: k = AOM_KIND_OTHER;
      default: begin
        if (m >= 7'h60 && m <= 7'h6d) begin
          k = AOM_KIND_OTHER;
        end
      end
    endcase
    return k;
  endfunction

  // the most negative amount still yields its true magnitude as unsigned
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  aom_state_e state_q;
  aom_kind_e kind_q;
  logic [6:0] mode_q;
  logic [31:0] rem_q;
  logic dir_q;
  logic [$clog2(DIV)-1:0] div_q;
  logic tick;
  logic pulse_q;
  logic done_q;
  logic [31:0] rdata_q;

  assign tick = (div_q == ($clog2(DIV))'(DIV - 1));

  // ---------------------------------------------------------------
  // start values
  // ---------------------------------------------------------------
  // target count and direction per positioning mode, taken with the start
  logic signed [31:0] target;
  logic signed [31:0] diff;
  logic [31:0] start_cnt;
  logic start_dir;
  always_comb begin
    target = i_move_amount;
    diff = 32'sh0;
    start_cnt = 32'h0;
    start_dir = 1'b0;
    case (i_mode_select)
      MODE_CONT_MINUS: start_dir = 1'b1;
      MODE_INCR: begin
        start_cnt = mag(i_move_amount);
        start_dir = i_move_amount[31];
      end
      MODE_ABS_C1, MODE_ABS_C2, MODE_ZERO_C1, MODE_ZERO_C2: begin
        if (i_mode_select == MODE_ZERO_C1 || i_mode_select == MODE_ZERO_C2) begin
          target = 32'sh0;
        end
        if (i_mode_select == MODE_ABS_C2 || i_mode_select == MODE_ZERO_C2) begin
          diff = target - i_counter2;
        end else begin
          diff = target - i_counter1;
        end
        start_cnt = mag(diff);
        start_dir = diff[31];
      end
      MODE_ONE_PLUS: start_cnt = 32'h1;
      MODE_ONE_MINUS: begin
        start_cnt = 32'h1;
        start_dir = 1'b1;
      end
      MODE_TIMER: start_cnt = 32'(i_move_amount);
      default: start_cnt = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // pulse-rate divider
  // ---------------------------------------------------------------
  // held at zero outside a run so the first pulse comes a full period after start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= '0;
    end else if (state_q != AOM_RUN || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= AOM_IDLE;
      kind_q <= AOM_KIND_CONT;
      mode_q <= MODE_RESET;
      rem_q <= 32'h0;
      dir_q <= 1'b0;
      pulse_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        AOM_IDLE: begin
          // a move-amount write while idle preloads the remaining count
          if (i_move_amount_wr) begin
            rem_q <= mag(i_move_amount);
          end
          if (i_start) begin
            mode_q <= i_mode_select;
            kind_q <= kind_of(i_mode_select);
            rem_q <= start_cnt;
            dir_q <= start_dir;
            // undefined and unimplemented codes finish at once rather than hang
            if (kind_of(i_mode_select) == AOM_KIND_CONT) begin
              state_q <= AOM_RUN;
            end else if ((kind_of(i_mode_select) == AOM_KIND_POS ||
                          kind_of(i_mode_select) == AOM_KIND_TIMER) && start_cnt != 32'h0) begin
              state_q <= AOM_RUN;
            end else begin
              state_q <= AOM_DONE;
            end
          end
        end
        AOM_RUN: begin
          // stop outranks the countdown so a late stop never adds a pulse
          if (i_stop) begin
            state_q <= AOM_DONE;
          end else begin
            if (i_move_amount_wr && kind_q == AOM_KIND_POS) begin
              rem_q <= mag(i_move_amount);
            end else if (tick && kind_q == AOM_KIND_CONT) begin
              pulse_q <= 1'b1;
            end else if (tick) begin
              // timer mode counts down without emitting pulses
              pulse_q <= (kind_q == AOM_KIND_POS);
              rem_q <= rem_q - 32'h1;
              if (rem_q == 32'h1) begin
                state_q <= AOM_DONE;
              end
            end
            if (i_move_amount_wr && kind_q == AOM_KIND_POS && i_move_amount == 32'sh0) begin
              state_q <= AOM_DONE;
            end
          end
        end
        // one cycle on the way to idle gives the done pulse its own slot
        AOM_DONE: begin
          done_q <= 1'b1;
          state_q <= AOM_IDLE;
        end
        default: state_q <= AOM_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status word and read port
  // ---------------------------------------------------------------
  // interpolation codes finish at once in this block, so the run flags only
  // rise once an executing interpolator is placed behind this decode
  logic lin1_mode;
  logic lin2_mode;
  logic cw_mode;
  logic ccw_mode;
  always_comb begin
    lin1_mode = 1'b0;
    lin2_mode = 1'b0;
    cw_mode = 1'b0;
    ccw_mode = 1'b0;
    case (mode_q)
      7'h60, 7'h61: lin1_mode = 1'b1;
      7'h62, 7'h63: lin2_mode = 1'b1;
      7'h64, 7'h66: cw_mode = 1'b1;
      7'h65, 7'h67: ccw_mode = 1'b1;
      default: lin1_mode = 1'b0;
    endcase
  end

  logic running;
  logic [31:0] status;
  assign running = (state_q == AOM_RUN);
  always_comb begin
    status = INTERP_STATUS_RESET;
    status[LIN1_SET_LSB +: 4] = i_lin1_set;
    status[LIN2_SET_LSB +: 4] = i_lin2_set;
    status[CIRC_SET_LSB +: 4] = i_circ_set;
    status[CONST_SPEED_LSB +: 4] = i_const_speed;
    // in-progress bits drop as soon as the run ends or is stopped
    status[LIN1_RUN_BIT] = running && lin1_mode;
    status[LIN2_RUN_BIT] = running && lin2_mode;
    status[CIRC_CW_BIT] = running && cw_mode;
    status[CIRC_CCW_BIT] = running && ccw_mode;
    if (status[CIRC_CW_BIT] || status[CIRC_CCW_BIT]) begin
      status[CUR_QUAD_LSB +: 2] = i_current_quadrant;
      status[FIN_QUAD_LSB +: 2] = i_final_quadrant;
    end
  end

  // captured on the strobe edge and held, so a slow host reads one consistent word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= INTERP_STATUS_RESET;
    end else if ((i_rd && (i_addr == INTERP_STATUS_ADDR_A || i_addr == INTERP_STATUS_ADDR_B)) ||
                 (i_cmd_wr && i_cmd == READ_INTERP_STATUS_CMD)) begin
      rdata_q <= status;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rdata = rdata_q;
  assign o_pulse = pulse_q;
  assign o_dir_minus = dir_q;
  assign o_busy = running;
  // deceleration is a flag only; the speed profile generator sits outside
  assign o_decel = running && i_high_speed && kind_q == AOM_KIND_POS &&
                   rem_q < i_decel_point;
  assign o_done = done_q;
  assign o_remaining_pulses = rem_q;
  assign o_mode_register = mode_q;
endmodule : aom_axis_mode_ctrl

// file: logic/aom_pkg.sv
// package: register offsets, commands, mode codes and status-word layout for the axis mode core
package aom_pkg;
  // ---------------------------------------------------------------
  // register addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] INTERP_STATUS_ADDR_A = 8'h00;
  localparam logic [7:0] INTERP_STATUS_ADDR_B = 8'hfc;
  localparam logic [7:0] READ_INTERP_STATUS_CMD = 8'hff;
  localparam logic [31:0] INTERP_STATUS_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int LIN1_SET_LSB = 0;
  localparam int LIN2_SET_LSB = 4;
  localparam int CIRC_SET_LSB = 8;
  localparam int CONST_SPEED_LSB = 12;
  localparam int LIN1_RUN_BIT = 16;
  localparam int LIN2_RUN_BIT = 17;
  localparam int CIRC_CW_BIT = 18;
  localparam int CIRC_CCW_BIT = 19;
  localparam int CUR_QUAD_LSB = 20;
  localparam int FIN_QUAD_LSB = 22;
  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [6:0] MODE_CONT_PLUS = 7'h00;
  localparam logic [6:0] MODE_CONT_MINUS = 7'h08;
  localparam logic [6:0] MODE_INCR = 7'h41;
  localparam logic [6:0] MODE_ABS_C1 = 7'h42;
  localparam logic [6:0] MODE_ABS_C2 = 7'h43;
  localparam logic [6:0] MODE_ZERO_C1 = 7'h44;
  localparam logic [6:0] MODE_ZERO_C2 = 7'h45;
  localparam logic [6:0] MODE_ONE_PLUS = 7'h46;
  localparam logic [6:0] MODE_ONE_MINUS = 7'h4e;
  localparam logic [6:0] MODE_TIMER = 7'h47;
  localparam logic [6:0] MODE_RESET = 7'h00;
  // ---------------------------------------------------------------
  // control and kinds
  // ---------------------------------------------------------------
  localparam int PULSE_DIV = 100;
  typedef enum logic [2:0] {
    AOM_KIND_CONT = 3'b000,
    AOM_KIND_POS = 3'b001,
    AOM_KIND_TIMER = 3'b010,
    AOM_KIND_OTHER = 3'b011,
    AOM_KIND_BAD = 3'b100
  } aom_kind_e;
  typedef enum logic [1:0] {
    AOM_IDLE = 2'b00,
    AOM_RUN = 2'b01,
    AOM_DONE = 2'b10
  } aom_state_e;
endpackage : aom_pkg
